/* File: logic/rbeb_top.sv */
// Remote bus extender bridge: host port, remote link, front-end arbiter, watchdogs
`timescale 1ns/1ns
module rbeb_top #(
	parameter int unsigned WDG_CYC      = rbeb_pkg::WDG_CYC,
	parameter int unsigned HALT_CYC     = rbeb_pkg::HALT_CYC,
	parameter int unsigned REM_TMO_CYC  = rbeb_pkg::REM_TMO_CYC,
	parameter int unsigned MAIN_TMO_CYC = rbeb_pkg::MAIN_TMO_CYC,
	parameter int unsigned FE_TMO_CYC   = rbeb_pkg::FE_TMO_CYC,
	parameter int unsigned PRES_CYC     = rbeb_pkg::PRES_CYC
) (
	input  wire logic                                 clk,
	input  wire logic                                 sys_rst,
	// Host (main processor) port
	input  wire logic                                 host_req,
	input  wire logic                                 host_we,
	input  wire logic                                 host_sel_fe,
	input  wire logic [rbeb_pkg::ADDR_W-1:0]          host_addr,
	input  wire logic [rbeb_pkg::DATA_W-1:0]          host_wdata,
	output logic                                      host_ack,
	output logic                                      host_err,
	output logic [rbeb_pkg::DATA_W-1:0]               host_rdata,
	// Remote serial link
	output logic                                      tx_sd,
	output logic                                      tx_frame,
	input  wire logic                                 rx_sd,
	input  wire logic                                 rx_frame,
	input  wire logic                                 dock_pres_a,
	input  wire logic                                 dock_pres_b,
	output logic                                      link_up,
	output logic                                      undock_confirmed,
	output logic                                      presence_fault,
	output logic                                      crc_irq,
	// Front-end bus
	input  wire logic [rbeb_pkg::FE_MASTERS-1:0]      fe_req,
	output logic [rbeb_pkg::FE_MASTERS-1:0]           fe_gnt,
	output logic                                      fe_tmo,
	output logic                                      fe_we,
	output logic [rbeb_pkg::ADDR_W-1:0]               fe_addr,
	output logic [rbeb_pkg::DATA_W-1:0]               fe_wdata,
	input  wire logic                                 fe_ack,
	input  wire logic [rbeb_pkg::DATA_W-1:0]          fe_rdata,
	input  wire logic                                 fep_main_req,
	output logic                                      fep_main_refused,
	// Watchdogs and alarm
	input  wire logic                                 wdg_kick_main,
	input  wire logic                                 wdg_kick_fe,
	output logic                                      sys_reset_req,
	output logic                                      sounder_on
);

	typedef struct packed {
		rbeb_pkg::rbeb_st_e               st;
		logic [31:0]                      tmo;
		logic                             ack;
		logic                             err;
		logic [rbeb_pkg::DATA_W-1:0]      rdata;
		logic                             irq;
		logic                             up;
		logic                             undock;
		logic [31:0]                      pres_cnt;
		logic                             pres_fault;
		logic [rbeb_pkg::FE_MASTERS-1:0]  gnt;
		logic [2:0]                       last;
		logic [31:0]                      fe_cnt;
		logic                             fe_tmo;
		logic                             refused;
		rbeb_pkg::rbeb_wd_e               wd;
		logic [31:0]                      wdm;
		logic [31:0]                      wdf;
		logic [7:0]                       rst_cnt;
		logic [31:0]                      halt_cnt;
		logic                             sounder;
	} rbeb_state_s;

	rbeb_state_s s_q;
	rbeb_state_s s_d;

	rbeb_link_if lnk ();

	logic                              tx_load;
	logic [rbeb_pkg::FE_MASTERS-1:0]   req_all;

	// Round-robin pick: first requester after the last owner
	function automatic logic [2:0] rbeb_pick(input logic [rbeb_pkg::FE_MASTERS-1:0] req,
		input logic [2:0] last);
		logic [2:0] idx;
		logic [2:0] res;
		res = last;
		for (int i = rbeb_pkg::FE_MASTERS; i >= 1; i--)
		begin
			idx = 3'((int'(last) + i) % rbeb_pkg::FE_MASTERS);
			if (req[idx])
				res = idx;
		end
		return res;
	endfunction

	rbeb_serdes u_serdes (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.lnk      (lnk),
		.tx_sd    (tx_sd),
		.tx_frame (tx_frame),
		.rx_sd    (rx_sd),
		.rx_frame (rx_frame)
	);

	assign lnk.tx_load = tx_load;
	assign lnk.tx_word = {host_we, host_addr, host_wdata};

	// Main processor appears as one master of the front-end bus
	always_comb
	begin
		req_all = fe_req;
		req_all[rbeb_pkg::FE_M_MAIN] = (s_q.st == rbeb_pkg::ST_FE_WAIT);
	end

	always_comb
	begin
		s_d = s_q;
		tx_load = 1'b0;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		s_d.irq = 1'b0;
		s_d.undock = 1'b0;
		s_d.fe_tmo = 1'b0;

		// ***************************************************
		// Presence and link state
		// ***************************************************
		s_d.up = dock_pres_a & dock_pres_b;
		if (s_q.up && !dock_pres_a && !dock_pres_b)
			s_d.undock = 1'b1;
		// A lone presence drop is a fault, never taken as a deliberate undock
		if (dock_pres_a != dock_pres_b)
		begin
			if (s_q.pres_cnt >= PRES_CYC)
				s_d.pres_fault = 1'b1;
			else
				s_d.pres_cnt = s_q.pres_cnt + 32'h1;
		end
		else
		begin
			s_d.pres_cnt = '0;
			s_d.pres_fault = 1'b0;
		end
		if (lnk.rx_crc_err)
			s_d.irq = 1'b1;

		// ***************************************************
		// Host access sequencer
		// ***************************************************
		unique case (s_q.st)
			rbeb_pkg::ST_IDLE:
			begin
				s_d.tmo = '0;
				if (host_req && !s_q.ack)
				begin
					if (host_sel_fe)
						s_d.st = rbeb_pkg::ST_FE_WAIT;
					else if (!s_q.up)
					begin
						// Undocked: fail the access quietly instead of faulting
						s_d.ack = 1'b1;
						s_d.err = 1'b1;
					end
					else
						s_d.st = rbeb_pkg::ST_REM_LOAD;
				end
			end
			rbeb_pkg::ST_REM_LOAD:
			begin
				s_d.tmo = s_q.tmo + 32'h1;
				if (!s_q.up || s_q.tmo >= MAIN_TMO_CYC)
				begin
					s_d.ack = 1'b1;
					s_d.err = 1'b1;
					s_d.st = rbeb_pkg::ST_IDLE;
				end
				else if (!lnk.tx_busy)
				begin
					tx_load = 1'b1;
					s_d.tmo = '0;
					if (host_we)
					begin
						s_d.ack = 1'b1;
						s_d.st = rbeb_pkg::ST_IDLE;
					end
					else
						s_d.st = rbeb_pkg::ST_REM_WAIT;
				end
			end
			rbeb_pkg::ST_REM_WAIT:
			begin
				s_d.tmo = s_q.tmo + 32'h1;
				if (lnk.rx_valid)
				begin
					s_d.rdata = lnk.rx_data;
					s_d.ack = 1'b1;
					s_d.st = rbeb_pkg::ST_IDLE;
				end
				else if (!s_q.up || s_q.tmo >= REM_TMO_CYC)
				begin
					s_d.ack = 1'b1;
					s_d.err = 1'b1;
					s_d.st = rbeb_pkg::ST_IDLE;
				end
			end
			rbeb_pkg::ST_FE_WAIT:
			begin
				s_d.tmo = s_q.tmo + 32'h1;
				if (s_q.gnt[rbeb_pkg::FE_M_MAIN] && fe_ack)
				begin
					if (!host_we)
						s_d.rdata = fe_rdata;
					s_d.ack = 1'b1;
					s_d.st = rbeb_pkg::ST_IDLE;
				end
				else if (s_q.tmo >= MAIN_TMO_CYC)
				begin
					s_d.ack = 1'b1;
					s_d.err = 1'b1;
					s_d.st = rbeb_pkg::ST_IDLE;
				end
			end
		endcase

		// ***************************************************
		// Front-end bus arbiter
		// ***************************************************
		if (s_q.gnt == '0)
		begin
			s_d.fe_cnt = '0;
			if (req_all != '0)
			begin
				s_d.last = rbeb_pick(req_all, s_q.last);
				s_d.gnt = '0;
				s_d.gnt[s_d.last] = 1'b1;
			end
		end
		else if (!req_all[s_q.last] || (s_q.ack && s_q.last == 3'(rbeb_pkg::FE_M_MAIN)))
			s_d.gnt = '0;
		else if (s_q.fe_cnt >= FE_TMO_CYC)
		begin
			// Hung owner loses the bus so the others keep running
			s_d.gnt = '0;
			s_d.fe_tmo = 1'b1;
		end
		else
			s_d.fe_cnt = s_q.fe_cnt + 32'h1;

		// Nothing maps front-end requests onto the main bus
		s_d.refused = fep_main_req;

		// ***************************************************
		// Watchdogs and halt alarm
		// ***************************************************
		s_d.wdm = wdg_kick_main ? '0 : s_q.wdm + 32'h1;
		s_d.wdf = wdg_kick_fe ? '0 : s_q.wdf + 32'h1;
		unique case (s_q.wd)
			rbeb_pkg::WD_RUN:
			begin
				if (s_q.wdm >= WDG_CYC || s_q.wdf >= WDG_CYC)
				begin
					s_d.wd = rbeb_pkg::WD_RST;
					s_d.rst_cnt = rbeb_pkg::RST_CYC;
				end
			end
			rbeb_pkg::WD_RST:
			begin
				s_d.rst_cnt = s_q.rst_cnt - 8'h01;
				if (s_q.rst_cnt == 8'h01)
				begin
					s_d.wd = rbeb_pkg::WD_CHK;
					s_d.halt_cnt = '0;
				end
			end
			rbeb_pkg::WD_CHK:
			begin
				s_d.halt_cnt = s_q.halt_cnt + 32'h1;
				if (wdg_kick_main)
				begin
					s_d.wd = rbeb_pkg::WD_RUN;
					s_d.wdm = '0;
					s_d.wdf = '0;
				end
				else if (s_q.halt_cnt >= HALT_CYC)
					s_d.sounder = 1'b1;
			end
			default:
				s_d.wd = rbeb_pkg::WD_RUN;
		endcase
		if (s_q.wd != rbeb_pkg::WD_RUN)
		begin
			s_d.wdm = '0;
			s_d.wdf = '0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign host_ack = s_q.ack;
	assign host_err = s_q.err;
	assign host_rdata = s_q.rdata;
	assign link_up = s_q.up;
	assign undock_confirmed = s_q.undock;
	assign presence_fault = s_q.pres_fault;
	assign crc_irq = s_q.irq;
	assign fe_gnt = s_q.gnt;
	assign fe_tmo = s_q.fe_tmo;
	assign fe_we = host_we;
	assign fe_addr = host_addr;
	assign fe_wdata = host_wdata;
	assign fep_main_refused = s_q.refused;
	assign sys_reset_req = (s_q.wd == rbeb_pkg::WD_RST);
	assign sounder_on = s_q.sounder;

endmodule

/* File: logic/rbeb_pkg.sv */
// Constants, types and state encodings of the remote bus extender bridge
package rbeb_pkg;

	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 32;
	localparam int unsigned CRC_W    = 8;
	localparam logic [7:0]  CRC_POLY = 8'h07;
	localparam logic [7:0]  CRC_INIT = 8'h00;

	// Request frame: write flag, address, data; answer frame: data
	localparam int unsigned TX_BITS  = 1 + ADDR_W + DATA_W;
	localparam logic [6:0]  TX_TOTAL = 7'h49;
	localparam logic [5:0]  RX_TOTAL = 6'h28;

	localparam int unsigned FE_MASTERS = 5;
	localparam int unsigned FE_M_FEP   = 0;
	localparam int unsigned FE_M_MAIN  = 1;
	localparam int unsigned FE_M_DSP   = 2;
	localparam int unsigned FE_M_POD   = 3;
	localparam int unsigned FE_M_REF   = 4;

	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned WDG_TIME_MS  = 1000;
	localparam int unsigned HALT_TIME_MS = 100;
	localparam int unsigned WDG_CYC      = WDG_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned HALT_CYC     = HALT_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned REM_TMO_CYC  = 1024;
	localparam int unsigned MAIN_TMO_CYC = 2048;
	localparam int unsigned FE_TMO_CYC   = 256;
	localparam int unsigned PRES_CYC     = 64;
	localparam logic [7:0]  RST_CYC      = 8'h10;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REM_LOAD,
		ST_REM_WAIT,
		ST_FE_WAIT
	} rbeb_st_e;

	typedef enum logic [1:0] {
		WD_RUN,
		WD_RST,
		WD_CHK
	} rbeb_wd_e;

	function automatic logic [7:0] rbeb_crc_step(input logic [7:0] c, input logic b);
		logic fb;
		fb = c[7] ^ b;
		return {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
	endfunction

endpackage

/* File: logic/rbeb_link_if.sv */
// Word-level hand-off between the bridge control and its serial shifter
`timescale 1ns/1ns
interface rbeb_link_if;
	logic                                   tx_load;
	logic [rbeb_pkg::TX_BITS-1:0]           tx_word;
	logic                                   tx_busy;
	logic                                   rx_valid;
	logic [rbeb_pkg::DATA_W-1:0]            rx_data;
	logic                                   rx_crc_err;

	modport ctl (output tx_load, output tx_word, input tx_busy,
		input rx_valid, input rx_data, input rx_crc_err);
	modport ser (input tx_load, input tx_word, output tx_busy,
		output rx_valid, output rx_data, output rx_crc_err);
endinterface

/* File: logic/rbeb_serdes.sv */
// Serial shifter with CRC generation and checking for the remote link
`timescale 1ns/1ns
module rbeb_serdes (
	input  wire logic  clk,
	input  wire logic  sys_rst,
	rbeb_link_if.ser   lnk,
	output logic       tx_sd,
	output logic       tx_frame,
	input  wire logic  rx_sd,
	input  wire logic  rx_frame
);

	typedef struct packed {
		logic [rbeb_pkg::TX_BITS-1:0] tx_sh;
		logic [6:0]                   tx_cnt;
		logic [7:0]                   tx_crc;
		logic                         tx_on;
		logic                         tx_sd;
		logic                         tx_frame;
		logic [39:0]                  rx_sh;
		logic [5:0]                   rx_cnt;
		logic [7:0]                   rx_crc;
		logic                         rx_on;
		logic                         rx_valid;
		logic                         rx_err;
		logic [rbeb_pkg::DATA_W-1:0]  rx_data;
	} rbeb_ser_s;

	rbeb_ser_s s_q;
	rbeb_ser_s s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.rx_valid = 1'b0;
		s_d.rx_err = 1'b0;
		// Transmit: payload first, then the CRC register shifted out MSB first
		if (lnk.tx_load)
		begin
			s_d.tx_sh = lnk.tx_word;
			s_d.tx_cnt = rbeb_pkg::TX_TOTAL;
			s_d.tx_crc = rbeb_pkg::CRC_INIT;
			s_d.tx_on = 1'b1;
		end
		else if (s_q.tx_on)
		begin
			if (s_q.tx_cnt == 7'h00)
			begin
				s_d.tx_on = 1'b0;
				s_d.tx_frame = 1'b0;
			end
			else
			begin
				s_d.tx_frame = 1'b1;
				s_d.tx_cnt = s_q.tx_cnt - 7'h01;
				if (s_q.tx_cnt > 7'(rbeb_pkg::CRC_W))
				begin
					s_d.tx_sd = s_q.tx_sh[rbeb_pkg::TX_BITS-1];
					s_d.tx_crc = rbeb_pkg::rbeb_crc_step(s_q.tx_crc,
						s_q.tx_sh[rbeb_pkg::TX_BITS-1]);
					s_d.tx_sh = {s_q.tx_sh[rbeb_pkg::TX_BITS-2:0], 1'b0};
				end
				else
				begin
					s_d.tx_sd = s_q.tx_crc[7];
					s_d.tx_crc = {s_q.tx_crc[6:0], 1'b0};
				end
			end
		end
		// Receive: running CRC over data and trailer must end at zero
		s_d.rx_on = rx_frame;
		if (rx_frame)
		begin
			s_d.rx_sh = {s_q.rx_sh[38:0], rx_sd};
			s_d.rx_crc = rbeb_pkg::rbeb_crc_step(s_q.rx_crc, rx_sd);
			if (s_q.rx_cnt != 6'h3F)
				s_d.rx_cnt = s_q.rx_cnt + 6'h01;
		end
		else if (s_q.rx_on)
		begin
			if (s_q.rx_cnt == rbeb_pkg::RX_TOTAL && s_q.rx_crc == 8'h00)
			begin
				s_d.rx_valid = 1'b1;
				s_d.rx_data = s_q.rx_sh[39:8];
			end
			else
				s_d.rx_err = 1'b1;
			s_d.rx_cnt = 6'h00;
			s_d.rx_crc = rbeb_pkg::CRC_INIT;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign lnk.tx_busy = s_q.tx_on;
	assign lnk.rx_valid = s_q.rx_valid;
	assign lnk.rx_data = s_q.rx_data;
	assign lnk.rx_crc_err = s_q.rx_err;
	assign tx_sd = s_q.tx_sd;
	assign tx_frame = s_q.tx_frame;

endmodule

/* File: tb/rbeb_monitor.sv */
// Port-level assertions for the bridge top, attached by bind
`timescale 1ns/1ns
module rbeb_monitor #(
	parameter int unsigned FE_TMO_CYC = 20
) (
	input wire logic				clk,
	input wire logic				sys_rst,
	input wire logic				host_req,
	input wire logic				host_we,
	input wire logic				host_sel_fe,
	input wire logic				host_ack,
	input wire logic				host_err,
	input wire logic				tx_frame,
	input wire logic				dock_pres_a,
	input wire logic				dock_pres_b,
	input wire logic				link_up,
	input wire logic				undock_confirmed,
	input wire logic				fep_main_req,
	input wire logic				fep_main_refused,
	input wire logic [rbeb_pkg::FE_MASTERS-1:0]	fe_gnt,
	input wire logic				sys_reset_req
);
	logic [15:0]	own_q;
	logic [15:0]	own_d;
	// Cycles the present owner has held the front-end bus
	assign own_d = (fe_gnt != '0) ? own_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			own_q <= 16'h0000;
		else
			own_q <= own_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_hold8;
		sys_reset_req [*8];
	endsequence
	sequence s_rd;
		$rose(host_req) && !host_we && !host_sel_fe && link_up;
	endsequence
	sequence s_wr;
		$rose(host_req) && host_we && !host_sel_fe && link_up && !tx_frame;
	endsequence
	a_reset_length: assert property ($rose(sys_reset_req) |-> s_hold8 ##1 s_hold8 ##1 !sys_reset_req)
		else $error("reset request length wrong");
	a_read_stall: assert property (s_rd |-> !host_ack [*8])
		else $error("remote read released early");
	a_write_release: assert property (s_wr |-> ##[1:3] host_ack)
		else $error("remote write not released");
	a_err_with_ack: assert property (host_err |-> host_ack)
		else $error("error without ack");
	a_link_follows: assert property (!$past(sys_rst) |-> link_up == $past(dock_pres_a && dock_pres_b))
		else $error("link state wrong");
	a_undock_cause: assert property (undock_confirmed |-> $past(!dock_pres_a && !dock_pres_b))
		else $error("undock without both presences low");
	a_refused_copy: assert property (!$past(sys_rst) |-> fep_main_refused == $past(fep_main_req))
		else $error("front-end attempt not refused");
	a_grant_onehot: assert property ($onehot0(fe_gnt))
		else $error("grant not one-hot");
	a_owner_bound: assert property (own_q <= FE_TMO_CYC + 2)
		else $error("owner kept bus past timeout");
endmodule
bind rbeb_top rbeb_monitor #(.FE_TMO_CYC(FE_TMO_CYC)) u_monitor (.clk, .sys_rst, .host_req,
	.host_we, .host_sel_fe, .host_ack, .host_err, .tx_frame, .dock_pres_a, .dock_pres_b,
	.link_up, .undock_confirmed, .fep_main_req, .fep_main_refused, .fe_gnt, .sys_reset_req);

/* File: tb/rbeb_remote_model.sv */
// Behavioural remote bus end: takes request frames, answers reads
`timescale 1ns/1ns
module rbeb_remote_model (
	input wire logic	clk,
	input wire logic	tx_sd,
	input wire logic	tx_frame,
	input wire logic	bad_crc,
	input wire logic	slow,
	output logic		rx_sd,
	output logic		rx_frame,
	output logic		seen,
	output logic		crc_ok,
	output logic [72:0]	req_q
);
	logic [6:0]	n_q = 7'h00;
	logic		ask_q = 1'b0;
	logic [39:0]	ans_q;
	// A whole frame with its own CRC appended leaves a zero remainder
	function automatic logic [7:0] crc_of(input logic [72:0] v, input int len);
		logic [7:0] c;
		c = 8'h00;
		for (int i = len - 1; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	always @(posedge clk)
	begin
		seen <= 1'b0;
		ask_q <= 1'b0;
		if (tx_frame)
		begin
			req_q <= {req_q[71:0], tx_sd};
			n_q <= n_q + 7'h01;
		end
		else if (n_q != 7'h00)
		begin
			seen <= 1'b1;
			crc_ok <= (n_q == 7'h49) && (crc_of(req_q, 73) == 8'h00);
			ask_q <= !req_q[72];
			ans_q <= {~req_q[71:40], crc_of({41'h0, ~req_q[71:40]}, 32) ^ {7'h00, bad_crc}};
			n_q <= 7'h00;
		end
	end
	// Idle line toggles so a stale level is never mistaken for data
	initial
	begin
		rx_frame = 1'b0;
		rx_sd = 1'b0;
		forever
		begin
			@(posedge clk);
			if (!ask_q)
				rx_sd <= ~rx_sd;
			else
			begin
				repeat (slow ? 30 : 1)
				begin
					rx_sd <= ~rx_sd;
					@(posedge clk);
				end
				for (int i = 39; i >= 0; i--)
				begin
					rx_frame <= 1'b1;
					rx_sd <= ans_q[i];
					@(posedge clk);
				end
				rx_frame <= 1'b0;
				rx_sd <= ~ans_q[0];
			end
		end
	end
endmodule

/* File: tb/test_remote_bus_extender_bridge.sv */
// Self-checking bench of the bridge with a behavioural remote end
`timescale 1ns/1ns
module test_remote_bus_extender_bridge;
	logic		clk, sys_rst, host_req, host_we, host_sel_fe, host_ack, host_err;
	logic		tx_sd, tx_frame, rx_sd, rx_frame, dock_pres_a, dock_pres_b, link_up;
	logic		undock_confirmed, presence_fault, crc_irq, fe_tmo, fe_we, fe_ack;
	logic		fep_main_req, fep_main_refused, wdg_kick_main, wdg_kick_fe;
	logic		sys_reset_req, sounder_on, bad_crc, slow, seen, crc_ok;
	logic		kick_en, fe_en, fe_busy, fe_wq, ok, er;
	logic [31:0]	host_addr, host_wdata, host_rdata, fe_addr, fe_wdata, fe_rdata, fe_cap, rd;
	logic [4:0]	fe_req, fe_gnt;
	logic [72:0]	req_q;
	int		err_count, checked, irq_n, und_n, cyc, lat, k, u0;
	// Presence filter keeps its default so the shipped value is the one exercised
	rbeb_top #(.WDG_CYC(200), .HALT_CYC(100), .REM_TMO_CYC(200), .MAIN_TMO_CYC(300),
		.FE_TMO_CYC(20)) dut (.clk, .sys_rst, .host_req, .host_we, .host_sel_fe,
		.host_addr, .host_wdata, .host_ack, .host_err, .host_rdata, .tx_sd, .tx_frame,
		.rx_sd, .rx_frame, .dock_pres_a, .dock_pres_b, .link_up, .undock_confirmed,
		.presence_fault, .crc_irq, .fe_req, .fe_gnt, .fe_tmo, .fe_we, .fe_addr, .fe_wdata,
		.fe_ack, .fe_rdata, .fep_main_req, .fep_main_refused, .wdg_kick_main,
		.wdg_kick_fe, .sys_reset_req, .sounder_on);
	rbeb_remote_model model (.clk, .tx_sd, .tx_frame, .bad_crc, .slow, .rx_sd,
		.rx_frame, .seen, .crc_ok, .req_q);
	always #20 clk = ~clk;
	// Kicks, event counters and a one-shot front-end slave
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		wdg_kick_main <= kick_en && (cyc % 50 == 0);
		wdg_kick_fe <= kick_en && (cyc % 50 == 25);
		irq_n <= irq_n + (crc_irq === 1'b1);
		und_n <= und_n + (undock_confirmed === 1'b1);
		fe_busy <= fe_gnt[1] && (fe_busy || fe_ack);
		fe_ack <= fe_en && fe_gnt[1] && !fe_busy && !fe_ack;
		fe_rdata <= ~fe_addr;
		if (fe_ack === 1'b1)
		begin
			fe_cap <= fe_wdata;
			fe_wq <= fe_we;
		end
	end
	task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
		checked++;
		if (sv !== ev)
		begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, sv, ev);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		k = 0;
		while (s !== 1'b1 && k < lim)
		begin
			@(posedge clk);
			k++;
		end
		ok = k < lim;
	endtask
	task automatic acc(input logic fe, input logic we, input logic [31:0] a, input logic [31:0] d);
		host_req <= 1'b1;
		host_we <= we;
		host_sel_fe <= fe;
		host_addr <= a;
		host_wdata <= d;
		lat = 0;
		do
		begin
			@(posedge clk);
			lat++;
		end
		while (host_ack !== 1'b1 && lat < 400);
		rd = host_rdata;
		er = host_err;
		host_req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic t_write();
		acc(1'b0, 1'b1, 32'h1234_5678, 32'hCAFE_F00D);
		chk(er, 1'b0);
		chk(lat <= 4, 1'b1);
		wait_hi(seen, 100);
		chk(ok, 1'b1);
		chk(req_q[72], 1'b1);
		chk(req_q[71:40], 32'h1234_5678);
		chk(req_q[39:8], 32'hCAFE_F00D);
		chk(crc_ok, 1'b1);
		$display("test write done");
	endtask
	task automatic t_read();
		slow <= 1'b1;
		acc(1'b0, 1'b0, 32'h0F0F_A5A5, 32'h0);
		chk(er, 1'b0);
		chk(rd, 32'hF0F0_5A5A);
		chk(lat > 140, 1'b1);
		slow <= 1'b0;
		acc(1'b0, 1'b0, 32'h8000_0001, 32'h0);
		chk(rd, 32'h7FFF_FFFE);
		chk(crc_ok, 1'b1);
		$display("test read done");
	endtask
	task automatic t_badcrc();
		bad_crc <= 1'b1;
		u0 = irq_n;
		acc(1'b0, 1'b0, 32'h0000_00FF, 32'h0);
		chk(irq_n - u0, 1);
		chk(er, 1'b1);
		chk(lat >= 200, 1'b1);
		bad_crc <= 1'b0;
		$display("test crc done");
	endtask
	task automatic t_dock();
		u0 = und_n;
		dock_pres_a <= 1'b0;
		repeat (70) @(posedge clk);
		chk(presence_fault, 1'b1);
		chk(und_n - u0, 0);
		dock_pres_a <= 1'b1;
		repeat (3) @(posedge clk);
		chk(link_up, 1'b1);
		dock_pres_a <= 1'b0;
		dock_pres_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk(und_n - u0, 1);
		acc(1'b0, 1'b1, 32'h1, 32'h2);
		chk(er, 1'b1);
		dock_pres_a <= 1'b1;
		dock_pres_b <= 1'b1;
		repeat (3) @(posedge clk);
		chk(link_up, 1'b1);
		$display("test dock done");
	endtask
	task automatic t_fe();
		for (int i = 0; i < 5; i++)
		begin
			fe_req <= (i == 1) ? 5'h00 : 5'h01 << i;
			repeat (2) @(posedge clk);
			chk(fe_gnt, (i == 1) ? 5'h00 : 5'h01 << i);
			fe_req <= 5'h00;
			repeat (3) @(posedge clk);
		end
		fe_req <= 5'h1D;
		wait_hi(fe_tmo, 40);
		chk(ok, 1'b1);
		fe_req <= 5'h00;
		fep_main_req <= 1'b1;
		repeat (2) @(posedge clk);
		chk(fep_main_refused, 1'b1);
		chk(host_ack, 1'b0);
		fep_main_req <= 1'b0;
		repeat (3) @(posedge clk);
		acc(1'b1, 1'b1, 32'h0000_0040, 32'h5555_AAAA);
		chk(er, 1'b0);
		chk(fe_cap, 32'h5555_AAAA);
		chk(fe_wq, 1'b1);
		acc(1'b1, 1'b0, 32'h0000_0044, 32'h0);
		chk(rd, 32'hFFFF_FFBB);
		chk(fe_wq, 1'b0);
		fe_en <= 1'b0;
		acc(1'b1, 1'b0, 32'h0000_0048, 32'h0);
		chk(er, 1'b1);
		fe_en <= 1'b1;
		$display("test front end done");
	endtask
	task automatic t_wdg();
		kick_en <= 1'b0;
		wait_hi(sys_reset_req, 300);
		chk(ok, 1'b1);
		k = 0;
		while (sys_reset_req === 1'b1 && k < 40)
		begin
			@(posedge clk);
			k++;
		end
		chk(k, 16);
		wait_hi(sounder_on, 200);
		chk(ok, 1'b1);
		$display("test watchdog done");
	endtask
	initial
	begin
		{clk, sys_rst, dock_pres_a, dock_pres_b, fe_en, kick_en} = 6'h3F;
		{host_req, host_we, host_sel_fe, bad_crc, slow, fep_main_req} = 6'h00;
		{host_addr, host_wdata, fe_req} = '0;
		{err_count, checked} = '0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_write();
		t_read();
		t_badcrc();
		t_dock();
		t_fe();
		t_wdg();
		give_verdict();
	end
	// Whole run needs well under two thousand cycles
	initial
	begin
		#800000;
		err_count++;
		give_verdict();
	end
endmodule
